// *** logic/aci_defs.svh ***
`ifndef ACI_DEFS_SVH
`define ACI_DEFS_SVH
// Summary of operation
// - outside 256-colour mode, colour-set bits 3:2 form index bits 7:6.
// - in 256-colour mode the fetched 8-bit attribute is the index.
// - mode bit 7 clear: six palette bits plus colour-set bits 3:2.
// - mode bit 7 set: low four palette bits plus all four colour-set bits.
// - colour-set register ignored in 256-colour mode.
// - pan-compat set: line compare forces pan zero until vertical sync.
// - character-map writes apply at the start of the next character row.
// - cursor start above cursor end shows no cursor; never split.
// - underline solid in 8-dot, dashed in 9-dot, solid for codes c0-df.
// - data registers share one port, selected by the held index.
// - each host memory read loads four byte latches, 32 bits.
// - write mode 1 stores the latch contents to memory.
// - glyphs up to 32 lines, eight tables, attribute bit 3 selects two.
// - glyph slot at code times 32; byte n is row scan n.
// - index/data toggle flips on write, status read clears it.
// - each palette entry holds six bits feeding the index.
`define ACI_PORT_WR      16'h03c0
`define ACI_PORT_RD      16'h03c1
`define ACI_PORT_STAT_M  16'h03ba
`define ACI_PORT_STAT_C  16'h03da
`define ACI_IDX_PAL_LAST 5'h0f
`define ACI_IDX_MODE     5'h10
`define ACI_IDX_OVSCAN   5'h11
`define ACI_IDX_PLANE    5'h12
`define ACI_IDX_PAN      5'h13
`define ACI_IDX_CSEL     5'h14
`define ACI_MODE_P54     7
`define ACI_MODE_PW8     6
`define ACI_MODE_PANC    5
`define ACI_LG_FIRST     8'hc0
`define ACI_LG_LAST      8'hdf
`define ACI_DOT9_COL     4'h8
`define ACI_RST_BYTE     8'h00
`endif

// *** logic/aci_pkg.sv ***
package aci_pkg;
	// index/data selector of the attribute port
	typedef enum logic {ACI_SEL_INDEX, ACI_SEL_DATA} aci_sel_e;
	// one host i/o cycle
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} aci_io_s;
	// host access to video memory
	typedef struct packed {
		logic        rd;
		logic [31:0] rdata;
		logic [1:0]  wmode;
		logic [7:0]  wbyte;
	} aci_mem_s;
endpackage

// *** logic/aci_top.sv ***
`timescale 1ns/100ps
`include "aci_defs.svh"
module aci_top #(
	parameter int PAL_N = 16
) (
	input  wire logic            ref_clk,
	input  wire logic            rst,
	input  wire logic            seq_hold,
	input  wire aci_pkg::aci_io_s io_req,
	output logic [7:0]           io_rdata,
	input  wire aci_pkg::aci_mem_s mem_req,
	output logic [31:0]          mem_wdata,
	input  wire logic [7:0]      pixel_attr,
	output logic [7:0]           converter_index_bits,
	input  wire logic            line_cmp,
	input  wire logic            vsync,
	output logic [3:0]           pan_out,
	input  wire logic            cmap_wr,
	input  wire logic [5:0]      cmap_wdata,
	input  wire logic            row_start,
	output logic [5:0]           cmap_active,
	input  wire logic [4:0]      cur_start,
	input  wire logic [4:0]      cur_end,
	input  wire logic [4:0]      scan_line,
	input  wire logic            cur_here,
	output logic                 cursor_dot,
	input  wire logic            ul_row,
	input  wire logic            dot9,
	input  wire logic [3:0]      dot_col,
	input  wire logic [7:0]      char_code,
	input  wire logic [7:0]      char_attr,
	input  wire logic [4:0]      max_scan,
	output logic                 ul_dot,
	output logic [15:0]          font_addr,
	output logic                 font_rd
);
	import aci_pkg::*;

	// ==========================================================
	// host port decode
	aci_sel_e   sel_ff, nxt_sel;
	logic [5:0] index_ff, nxt_index;
	logic [5:0] pal_ff [PAL_N];
	logic [5:0] nxt_pal [PAL_N];
	logic [7:0] mode_ff, nxt_mode;
	logic [7:0] ovs_ff, nxt_ovs;
	logic [5:0] plane_ff, nxt_plane;
	logic [3:0] pan_ff, nxt_pan;
	logic [3:0] csel_ff, nxt_csel;
	logic [7:0] rdata_ff, nxt_rdata;
	logic       wr_port;
	logic       stat_rd;
	logic       data_wr;

	assign wr_port = io_req.wr && (io_req.addr == `ACI_PORT_WR);
	assign stat_rd = io_req.rd && ((io_req.addr == `ACI_PORT_STAT_M) ||
	                               (io_req.addr == `ACI_PORT_STAT_C));
	assign data_wr = wr_port && (sel_ff == ACI_SEL_DATA);

	// toggle, index and indexed data registers
	always_comb begin
		nxt_sel   = sel_ff;
		nxt_index = index_ff;
		nxt_pal   = pal_ff;
		nxt_mode  = mode_ff;
		nxt_ovs   = ovs_ff;
		nxt_plane = plane_ff;
		nxt_pan   = pan_ff;
		nxt_csel  = csel_ff;
		if (stat_rd) begin
			nxt_sel = ACI_SEL_INDEX;
		end else if (wr_port) begin
			nxt_sel = (sel_ff == ACI_SEL_INDEX) ? ACI_SEL_DATA : ACI_SEL_INDEX;
		end
		if (wr_port && sel_ff == ACI_SEL_INDEX) begin
			nxt_index = io_req.wdata[5:0];
		end
		if (data_wr) begin
			case (index_ff[4:0])
				`ACI_IDX_MODE:   nxt_mode  = io_req.wdata & 8'hef;
				`ACI_IDX_OVSCAN: nxt_ovs   = io_req.wdata;
				`ACI_IDX_PLANE:  nxt_plane = io_req.wdata[5:0];
				`ACI_IDX_PAN:    nxt_pan   = io_req.wdata[3:0];
				`ACI_IDX_CSEL:   nxt_csel  = io_req.wdata[3:0];
				default: begin
					if (index_ff[4:0] <= `ACI_IDX_PAL_LAST) begin
						nxt_pal[index_ff[3:0]] = io_req.wdata[5:0];
					end
				end
			endcase
		end
	end

	// read data; unmapped ports and indices read zero
	always_comb begin
		nxt_rdata = `ACI_RST_BYTE;
		if (io_req.rd && io_req.addr == `ACI_PORT_WR) begin
			nxt_rdata = {2'h0, index_ff};
		end else if (io_req.rd && io_req.addr == `ACI_PORT_RD) begin
			case (index_ff[4:0])
				`ACI_IDX_MODE:   nxt_rdata = mode_ff;
				`ACI_IDX_OVSCAN: nxt_rdata = ovs_ff;
				`ACI_IDX_PLANE:  nxt_rdata = {2'h0, plane_ff};
				`ACI_IDX_PAN:    nxt_rdata = {4'h0, pan_ff};
				`ACI_IDX_CSEL:   nxt_rdata = {4'h0, csel_ff};
				default: begin
					if (index_ff[4:0] <= `ACI_IDX_PAL_LAST) begin
						nxt_rdata = {2'h0, pal_ff[index_ff[3:0]]};
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sel_ff   <= ACI_SEL_INDEX;
			index_ff <= 6'h00;
			for (int i = 0; i < PAL_N; i++) begin
				pal_ff[i] <= 6'h00;
			end
			mode_ff  <= `ACI_RST_BYTE;
			ovs_ff   <= `ACI_RST_BYTE;
			plane_ff <= 6'h00;
			pan_ff   <= 4'h0;
			csel_ff  <= 4'h0;
			rdata_ff <= `ACI_RST_BYTE;
		end else begin
			sel_ff   <= nxt_sel;
			index_ff <= nxt_index;
			pal_ff   <= nxt_pal;
			mode_ff  <= nxt_mode;
			ovs_ff   <= nxt_ovs;
			plane_ff <= nxt_plane;
			pan_ff   <= nxt_pan;
			csel_ff  <= nxt_csel;
			rdata_ff <= nxt_rdata;
		end
	end

	assign io_rdata = rdata_ff;

	// ==========================================================
	// colour index path
	logic [7:0] cidx_ff, nxt_cidx;
	logic [5:0] pal_out;

	assign pal_out = pal_ff[pixel_attr[3:0] & plane_ff[3:0]];

	always_comb begin
		if (seq_hold) begin
			nxt_cidx = 8'h00;
		end else if (mode_ff[`ACI_MODE_PW8]) begin
			nxt_cidx = pixel_attr;
		end else if (mode_ff[`ACI_MODE_P54]) begin
			nxt_cidx = {csel_ff[3:2], csel_ff[1:0], pal_out[3:0]};
		end else begin
			nxt_cidx = {csel_ff[3:2], pal_out};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cidx_ff <= 8'h00;
		end else begin
			cidx_ff <= nxt_cidx;
		end
	end

	assign converter_index_bits = cidx_ff;

	// ==========================================================
	// pan suppression after line compare
	logic pan_zero_ff, nxt_pan_zero;

	// a compare landing in the sync cycle wins, so the suppression is not lost
	always_comb begin
		nxt_pan_zero = pan_zero_ff;
		if (!mode_ff[`ACI_MODE_PANC]) begin
			nxt_pan_zero = 1'b0;
		end else if (line_cmp) begin
			nxt_pan_zero = 1'b1;
		end else if (vsync) begin
			nxt_pan_zero = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pan_zero_ff <= 1'b0;
		end else begin
			pan_zero_ff <= nxt_pan_zero;
		end
	end

	assign pan_out = pan_zero_ff ? 4'h0 : pan_ff;

	// ==========================================================
	// character map switch at row boundary
	logic [5:0] cmap_pend_ff, nxt_cmap_pend;
	logic [5:0] cmap_ff, nxt_cmap;

	always_comb begin
		nxt_cmap_pend = cmap_wr ? cmap_wdata : cmap_pend_ff;
		nxt_cmap      = row_start ? nxt_cmap_pend : cmap_ff;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cmap_pend_ff <= 6'h00;
			cmap_ff      <= 6'h00;
		end else begin
			cmap_pend_ff <= nxt_cmap_pend;
			cmap_ff      <= nxt_cmap;
		end
	end

	assign cmap_active = cmap_ff;

	// ==========================================================
	// glyph fetch address: table, code times 32, row scan
	logic [2:0] table_sel;

	// attribute bit 3 picks table a, else table b
	assign table_sel = char_attr[3] ? {cmap_ff[5], cmap_ff[3:2]}
	                                : {cmap_ff[4], cmap_ff[1:0]};
	assign font_addr = {table_sel, char_code, scan_line};
	assign font_rd   = (scan_line <= max_scan);

	// ==========================================================
	// cursor and underline dots
	logic line_gfx;

	assign cursor_dot = cur_here && (cur_start <= cur_end) &&
	                    (scan_line >= cur_start) && (scan_line <= cur_end);
	assign line_gfx   = (char_code >= `ACI_LG_FIRST) && (char_code <= `ACI_LG_LAST);
	assign ul_dot     = ul_row && !(dot9 && dot_col == `ACI_DOT9_COL && !line_gfx);

	// ==========================================================
	// processor latches
	logic [31:0] latch_ff, nxt_latch;

	assign nxt_latch = mem_req.rd ? mem_req.rdata : latch_ff;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			latch_ff <= 32'h0000_0000;
		end else begin
			latch_ff <= nxt_latch;
		end
	end

	assign mem_wdata = (mem_req.wmode == 2'h1) ? latch_ff : {4{mem_req.wbyte}};

endmodule

// *** dv/aci_props.sv ***
`timescale 1ns/100ps
// ==========
// port checks of the colour index path
module aci_props (
	input wire logic		ref_clk,
	input wire logic		rst,
	input wire logic		seq_hold,
	input wire aci_pkg::aci_io_s	io_req,
	input wire logic [7:0]		io_rdata,
	input wire aci_pkg::aci_mem_s	mem_req,
	input wire logic [31:0]		mem_wdata,
	input wire logic [7:0]		converter_index_bits,
	input wire logic		cmap_wr,
	input wire logic [5:0]		cmap_wdata,
	input wire logic		row_start,
	input wire logic [5:0]		cmap_active,
	input wire logic [4:0]		cur_start,
	input wire logic [4:0]		cur_end,
	input wire logic		cursor_dot,
	input wire logic		ul_row,
	input wire logic		dot9,
	input wire logic [3:0]		dot_col,
	input wire logic [7:0]		char_code,
	input wire logic [4:0]		scan_line,
	input wire logic		ul_dot,
	input wire logic [15:0]		font_addr
);
	import aci_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// ninth dot of a plain character in a 9-dot row
	wire dash_dot = ul_row && dot9 && dot_col == 4'h8 && !(char_code inside {[8'hc0:8'hdf]});
	// latch load then store; map write then row start
	sequence s_load; mem_req.rd ##1 mem_req.wmode == 2'h1; endsequence
	sequence s_map; cmap_wr ##1 (row_start && !cmap_wr); endsequence
	a_hold_zero: assert property (seq_hold |=> converter_index_bits == 8'h00)
		else $error("index not zero in hold");
	a_rd_idle: assert property (!io_req.rd |=> io_rdata == 8'h00)
		else $error("read data without read");
	a_latch_out: assert property (s_load |-> mem_wdata == $past(mem_req.rdata))
		else $error("latch not stored");
	a_no_cursor: assert property (cur_start > cur_end |-> !cursor_dot)
		else $error("cursor shown");
	a_ul_dash: assert property (dash_dot |-> !ul_dot)
		else $error("ninth dot underlined");
	a_glyph_slot: assert property (font_addr[12:0] == {char_code, scan_line})
		else $error("glyph address wrong");
	a_map_steady: assert property (!row_start |=> $stable(cmap_active))
		else $error("map changed mid row");
	a_map_apply: assert property (s_map |=> cmap_active == $past(cmap_wdata, 2))
		else $error("map not applied");
endmodule

bind aci_top aci_props i_aci_props (.*);

// *** dv/aci_dac.sv ***
`timescale 1ns/100ps
// ==========
// converter: samples the index each edge, shows it two edges on
module aci_dac (
	input wire logic	ref_clk,
	input wire logic [7:0]	idx,
	input wire logic	v,
	output logic [7:0]	dac_idx,
	output logic		dac_v
);
	logic [7:0]	d1_ff, d2_ff;
	logic [3:0]	v_ff;
	// sample pipe, marker runs one edge behind the data
	always_ff @(posedge ref_clk) begin
		{dac_idx, d2_ff, d1_ff} <= {d2_ff, d1_ff, idx};
		v_ff <= {v_ff[2:0], v};
	end
	assign dac_v = v_ff[3];
endmodule

// *** dv/attribute_color_index_path_bench.sv ***
`timescale 1ns/100ps
// ==========
// bench of the colour index path
module attribute_color_index_path_bench;
	import aci_pkg::*;
	logic ref_clk = 1'b0, rst = 1'b1, seq_hold = 1'b0, pix_v = 1'b0, dac_v;
	logic line_cmp = 1'b0, vsync = 1'b0, cmap_wr = 1'b0, row_start = 1'b0;
	logic cur_here = 1'b0, ul_row = 1'b0, dot9 = 1'b0, cursor_dot, ul_dot, font_rd;
	logic [7:0] pixel_attr = '0, char_code = '0, char_attr = '0;
	logic [7:0] io_rdata, converter_index_bits, dac_idx;
	logic [4:0] cur_start = '0, cur_end = '0, scan_line = '0, max_scan = '0;
	logic [5:0] cmap_wdata = '0, cmap_active, pal [16];
	logic [3:0] dot_col = '0, pan_out, cs;
	logic [15:0] font_addr;
	logic [31:0] mem_wdata, rnd;
	logic [7:0] q [$], pq [$], modes [3] = '{8'h00, 8'h80, 8'h40};
	aci_io_s io_req = '0;
	aci_mem_s mem_req = '0;
	int err_count = 0, check_count = 0;
	aci_top i_aci_top (.*);
	aci_dac i_aci_dac (.ref_clk, .idx(converter_index_bits), .v(pix_v), .dac_idx, .dac_v);
	always #20 ref_clk = ~ref_clk;
	// ==========
	// tasks
	task automatic cmp(logic [31:0] got, logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		// notes never matched by a result count as mismatches
		if (q.size() != 0 || pq.size() != 0) err_count++;
		if (err_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one host cycle; d is the expected byte on a data read
	task automatic io(logic w, logic r, logic [15:0] a, logic [7:0] d);
		io_req <= '{w, r, a, d};
		if (r && a == 16'h03c1) q.push_back(d);
		@(posedge ref_clk);
		io_req <= '0;
		@(posedge ref_clk);
	endtask
	task automatic reg_wr(logic [7:0] i, logic [7:0] v);
		io(1'b0, 1'b1, 16'h03da, 8'h00);
		io(1'b1, 1'b0, 16'h03c0, i);
		io(1'b1, 1'b0, 16'h03c0, v);
	endtask
	task automatic pix(logic [7:0] a, logic [7:0] e);
		pixel_attr <= a;
		pix_v <= 1'b1;
		pq.push_back(e);
		@(posedge ref_clk);
	endtask
	function automatic logic [7:0] exp_idx(logic [7:0] md, logic [7:0] a);
		if (md[6]) return a;
		if (md[7]) return {cs, pal[a[3:0]][3:0]};
		return {cs[3:2], pal[a[3:0]]};
	endfunction
	// read data answers the read taken at this edge
	always @(posedge ref_clk) begin
		if (io_req.rd === 1'b1 && io_req.addr === 16'h03c1) #1 cmp(32'(io_rdata), 32'(q.pop_front()));
	end
	// indices handed back by the converter model
	always @(posedge ref_clk) begin
		if (dac_v === 1'b1 && pq.size() == 0) err_count++;
		else if (dac_v === 1'b1) cmp(32'(dac_idx), 32'(pq.pop_front()));
	end
	// ==========
	// scenarios
	initial begin
		// host leaves crt timing, line compare value and clock bits alone
		void'($urandom(32'hb63f));
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		cmp(32'(converter_index_bits), 32'h0);
		for (int i = 0; i < 16; i++) begin
			pal[i] = 6'($urandom);
			reg_wr(8'(i), {2'h0, pal[i]});
		end
		cs = 4'($urandom);
		reg_wr(8'h32, 8'h0f);
		reg_wr(8'h34, {4'h0, cs});
		io(1'b0, 1'b1, 16'h03c1, {4'h0, cs});
		io(1'b1, 1'b0, 16'h03c0, 8'h33);
		io(1'b1, 1'b0, 16'h03c0, 8'h05);
		io(1'b0, 1'b1, 16'h03c1, 8'h05);
		io(1'b1, 1'b0, 16'h03c0, 8'h06);
		io(1'b0, 1'b1, 16'h03c1, {2'h0, pal[6]});
		foreach (modes[m]) begin
			reg_wr(8'h30, modes[m]);
			for (int k = 0; k < 6; k++) begin
				rnd = $urandom;
				pix(rnd[7:0], exp_idx(modes[m], rnd[7:0]));
			end
			pix_v <= 1'b0;
			repeat (5) @(posedge ref_clk);
		end
		seq_hold <= 1'b1;
		@(posedge ref_clk);
		pix(8'ha5, 8'h00);
		pix(8'h3c, 8'h00);
		pix_v <= 1'b0;
		seq_hold <= 1'b0;
		repeat (5) @(posedge ref_clk);
		reg_wr(8'h30, 8'h20);
		cmp(32'(pan_out), 32'h5);
		line_cmp <= 1'b1;
		@(posedge ref_clk);
		line_cmp <= 1'b0;
		@(posedge ref_clk);
		cmp(32'(pan_out), 32'h0);
		vsync <= 1'b1;
		@(posedge ref_clk);
		vsync <= 1'b0;
		repeat (2) @(posedge ref_clk);
		cmp(32'(pan_out), 32'h5);
		reg_wr(8'h33, 8'h08);
		cmp(32'(pan_out), 32'h8);
		cmap_wdata <= 6'h2d;
		cmap_wr <= 1'b1;
		@(posedge ref_clk);
		cmap_wr <= 1'b0;
		@(posedge ref_clk);
		cmp(32'(cmap_active), 32'h0);
		row_start <= 1'b1;
		@(posedge ref_clk);
		row_start <= 1'b0;
		char_attr <= 8'h08;
		char_code <= 8'h41;
		scan_line <= 5'h04;
		@(posedge ref_clk);
		cmp(32'(cmap_active), 32'h2d);
		cmp(32'(font_addr), 32'({3'h7, 8'h41, 5'h04}));
		char_attr <= 8'h00;
		{cur_start, cur_end, cur_here} <= {5'h03, 5'h02, 1'b1};
		{ul_row, dot9, dot_col} <= {1'b1, 1'b1, 4'h8};
		@(posedge ref_clk);
		cmp(32'(font_addr), 32'({3'h1, 8'h41, 5'h04}));
		cmp(32'(cursor_dot), 32'h0);
		cmp(32'(ul_dot), 32'h0);
		cmp(32'(font_rd), 32'h0);
		// line graphics code, normal cursor, row inside the glyph
		char_code <= 8'hc4;
		max_scan <= 5'h0f;
		{cur_start, cur_end} <= {5'h02, 5'h05};
		@(posedge ref_clk);
		cmp(32'(ul_dot), 32'h1);
		cmp(32'(cursor_dot), 32'h1);
		cmp(32'(font_rd), 32'h1);
		rnd = $urandom;
		mem_req <= '{1'b1, rnd, 2'h1, 8'h3c};
		@(posedge ref_clk);
		mem_req.rd <= 1'b0;
		@(posedge ref_clk);
		cmp(mem_wdata, rnd);
		mem_req.wmode <= 2'h0;
		@(posedge ref_clk);
		cmp(mem_wdata, {4{8'h3c}});
		wrap_up();
	end
endmodule
